/* File: core/gts_tx_slot_config_regs.sv */
// Register bank for slot-transmit control, end slots and spacing
// Behaviour
// - Retry field writes the limit; reads give retries of last good send.
// - Slot field picks the slot in which the second FIFO frame goes out.
// - Ack request bit set: expect acknowledgement, resend when missing; resets zero.
// - Security bit set applies security to the frame; resets zero.
// - Writing one to trigger launches sending; hardware clears it; reads zero.
// - One register holds third and second slot ends, both resetting zero.
// - Another register holds fifth and fourth slot ends, both resetting zero.
// - Sixth slot end in low nibble; upper nibble reserved and reads zero.
//
// Chosen here: the Avalon-MM slave port.
module gts_tx_slot_config_regs
   import gts_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_clk_en,
   input  wire logic [5:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic [2:0]  i_current_slot,
   input  wire logic        i_frame_done,
   input  wire logic        i_ack_seen,
   output logic             o_slot_fifo_b_send,
   output logic             o_slot_fifo_b_busy,
   output logic             o_slot_fifo_b_done,
   output logic             o_slot_fifo_b_success,
   output logic             o_slot_fifo_b_ack_request,
   output logic             o_slot_fifo_b_security_on,
   output logic [2:0]       o_slot_fifo_b_slot_number,
   output logic [3:0]       o_second_slot_end,
   output logic [3:0]       o_third_slot_end,
   output logic [3:0]       o_fourth_slot_end,
   output logic [3:0]       o_fifth_slot_end,
   output logic [3:0]       o_sixth_slot_end,
   output logic [5:0]       o_long_spacing_symbols,
   output logic             o_slot_fifo_alternate_on_fail,
   output logic             o_ack_frame_pending
);
   import gts_pkg::*;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [1:0] retry_limit_ff;
   logic [1:0] retry_used_ff;
   logic       send_trigger_ff;
   logic [7:0] end23_ff;
   logic [7:0] end45_ff;
   logic [3:0] end6_ff;
   logic       done_w;
   logic       success_w;
   logic       busy_w;
   logic       send_w;
   logic [1:0] used_w;
   logic       start_w;
   logic       wr_ok;
   logic [7:0] wd;
   logic [7:0] rd_mux;

   // Register hit test, shared by the write and read decoders
   function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
      hit = (a == idx);
   endfunction

   // Writes land at the edge where waitrequest is seen low
   assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   assign wd    = i_avs_writedata[7:0];

   // ****************************************************************
   // Avalon handshake
   // ****************************************************************
   // One wait state per access; readdata is loaded as waitrequest drops
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
         o_avs_waitrequest <= 1'b1;
      else if (i_clk_en)
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
   end

   // Trigger reads as zero; unmapped indices read as zero
   always_comb
   begin
      rd_mux = 8'h00;
      if (hit(i_avs_address, IDX_CTRL))
         rd_mux = {retry_used_ff, o_slot_fifo_b_slot_number,
                   o_slot_fifo_b_ack_request, o_slot_fifo_b_security_on, 1'b0};
      else if (hit(i_avs_address, IDX_END23))
         rd_mux = end23_ff;
      else if (hit(i_avs_address, IDX_END45))
         rd_mux = end45_ff;
      else if (hit(i_avs_address, IDX_END6))
         rd_mux = {4'h0, end6_ff};
      else if (hit(i_avs_address, IDX_IFS))
         rd_mux = {o_long_spacing_symbols, o_slot_fifo_alternate_on_fail,
                   o_ack_frame_pending};
   end

   // Read data captured once per access
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
         o_avs_readdata <= 32'h0000_0000;
      else if (i_clk_en && i_avs_read && o_avs_waitrequest)
         o_avs_readdata <= {24'h00_0000, rd_mux};
   end

   // ****************************************************************
   // Second slot FIFO control
   // ****************************************************************
   // Limit, slot, ack request and security, written by software
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
      begin
         retry_limit_ff            <= 2'h0;
         o_slot_fifo_b_slot_number <= 3'h0;
         o_slot_fifo_b_ack_request <= 1'b0;
         o_slot_fifo_b_security_on <= 1'b0;
      end
      else if (i_clk_en && wr_ok && hit(i_avs_address, IDX_CTRL))
      begin
         retry_limit_ff            <= wd[RETRY_LSB +: 2];
         o_slot_fifo_b_slot_number <= wd[SLOT_LSB +: 3];
         o_slot_fifo_b_ack_request <= wd[ACK_BIT];
         o_slot_fifo_b_security_on <= wd[SEC_BIT];
      end
   end

   // Trigger: a software set in the finishing cycle wins over the clear
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
         send_trigger_ff <= 1'b0;
      else if (i_clk_en)
      begin
         if (wr_ok && hit(i_avs_address, IDX_CTRL) && wd[TRIG_BIT])
            send_trigger_ff <= 1'b1;
         else if (done_w)
            send_trigger_ff <= 1'b0;
      end
   end

   // Retry readback follows only successful frames
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
         retry_used_ff <= 2'h0;
      else if (i_clk_en && done_w && success_w)
         retry_used_ff <= used_w;
   end

   // Done cycle blocks restart, so a finished frame is not resent
   assign start_w = send_trigger_ff && !busy_w && !done_w;

   gts_sender u_sender
   (
      .i_clk_sys      (i_clk_sys),
      .i_reset        (i_reset),
      .i_clk_en       (i_clk_en),
      .i_start        (start_w),
      .i_retry_limit  (retry_limit_ff),
      .i_ack_request  (o_slot_fifo_b_ack_request),
      .i_slot_number  (o_slot_fifo_b_slot_number),
      .i_current_slot (i_current_slot),
      .i_frame_done   (i_frame_done),
      .i_ack_seen     (i_ack_seen),
      .o_send         (send_w),
      .o_busy         (busy_w),
      .o_done         (done_w),
      .o_success      (success_w),
      .o_retries_used (used_w)
   );

   // Status mirrors of the sender flops; busy mirrors the trigger flop
   assign o_slot_fifo_b_send    = send_w;
   assign o_slot_fifo_b_busy    = send_trigger_ff;
   assign o_slot_fifo_b_done    = done_w;
   assign o_slot_fifo_b_success = success_w;

   // ****************************************************************
   // End slots
   // ****************************************************************
   // Fifteen in the sixth end is software's job when a seventh exists
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
      begin
         end23_ff <= {END_RST, END_RST};
         end45_ff <= {END_RST, END_RST};
         end6_ff  <= END_RST;
      end
      else if (i_clk_en && wr_ok)
      begin
         if (hit(i_avs_address, IDX_END23))
            end23_ff <= wd;
         if (hit(i_avs_address, IDX_END45))
            end45_ff <= wd;
         if (hit(i_avs_address, IDX_END6))
            end6_ff <= wd[3:0];
      end
   end

   assign o_third_slot_end  = end23_ff[HI_LSB +: 4];
   assign o_second_slot_end = end23_ff[3:0];
   assign o_fifth_slot_end  = end45_ff[HI_LSB +: 4];
   assign o_fourth_slot_end = end45_ff[3:0];
   assign o_sixth_slot_end  = end6_ff;

   // ****************************************************************
   // Interframe spacing and pending control
   // ****************************************************************
   // Settle count is elsewhere; the two together must make forty symbols
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_long_spacing_symbols        <= SPACE_RST;
         o_slot_fifo_alternate_on_fail <= 1'b0;
         o_ack_frame_pending           <= 1'b0;
      end
      else if (i_clk_en && wr_ok && hit(i_avs_address, IDX_IFS))
      begin
         o_long_spacing_symbols        <= wd[SPACE_LSB +: 6];
         o_slot_fifo_alternate_on_fail <= wd[ALT_BIT];
         o_ack_frame_pending           <= wd[FP_BIT];
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset || !i_clk_en);

   sequence ctrl_write_s;
      wr_ok && hit(i_avs_address, IDX_CTRL);
   endsequence

   sequence good_finish_s;
      done_w && success_w;
   endsequence

   // Readback carries retries of the last successful send
   retry_readback_a: assert property (
      good_finish_s |=> retry_used_ff == $past(used_w))
      else $error("retry readback stale");

   // A send never leaves the programmed slot
   slot_gate_a: assert property (
      send_w |-> $past(i_current_slot == o_slot_fifo_b_slot_number))
      else $error("send in wrong slot");

   // Without ack request every finished frame counts as good
   ack_free_ok_a: assert property (
      (done_w && !o_slot_fifo_b_ack_request) |-> success_w)
      else $error("unacked frame failed");

   // Security bit follows the write
   security_write_a: assert property (
      ctrl_write_s |=> o_slot_fifo_b_security_on == $past(wd[SEC_BIT]))
      else $error("security bit not stored");

   // Trigger falls after finish unless software sets it again
   trigger_clear_a: assert property (
      (done_w && !(wr_ok && hit(i_avs_address, IDX_CTRL) && wd[TRIG_BIT]))
      |=> !send_trigger_ff)
      else $error("trigger not cleared");

   // Trigger write then launch within two cycles when idle
   trigger_launch_a: assert property (
      (ctrl_write_s ##0 (wd[TRIG_BIT] && !busy_w && !done_w))
      |=> send_trigger_ff ##1 busy_w)
      else $error("trigger did not launch");

   // Both end nibbles of the first pair store together
   end_pair_a: assert property (
      (wr_ok && hit(i_avs_address, IDX_END23))
      |=> {o_third_slot_end, o_second_slot_end} == $past(wd))
      else $error("end slot pair lost");

   // Second pair likewise
   end_pair2_a: assert property (
      (wr_ok && hit(i_avs_address, IDX_END45))
      |=> {o_fifth_slot_end, o_fourth_slot_end} == $past(wd))
      else $error("end slot pair two lost");

   // Reserved nibble of the sixth end reads zero
   end_reserved_a: assert property (
      (i_avs_read && o_avs_waitrequest && hit(i_avs_address, IDX_END6))
      |=> o_avs_readdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");

   // Spacing and alternate flag follow the write
   spacing_write_a: assert property (
      (wr_ok && hit(i_avs_address, IDX_IFS))
      |=> o_long_spacing_symbols == $past(wd[SPACE_LSB +: 6])
          && o_slot_fifo_alternate_on_fail == $past(wd[ALT_BIT]))
      else $error("spacing register lost");

   // Retry limit follows the write
   retry_limit_a: assert property (
      ctrl_write_s |=> retry_limit_ff == $past(wd[RETRY_LSB +: 2]))
      else $error("retry limit not stored");

   // Slot number follows the write
   slot_write_a: assert property (
      ctrl_write_s |=> o_slot_fifo_b_slot_number == $past(wd[SLOT_LSB +: 3]))
      else $error("slot number not stored");

   // Ack request follows the write
   ack_write_a: assert property (
      ctrl_write_s |=> o_slot_fifo_b_ack_request == $past(wd[ACK_BIT]))
      else $error("ack request not stored");

   // Trigger is write-only, so a control read shows it as zero
   trigger_read_a: assert property (
      (i_avs_read && o_avs_waitrequest && hit(i_avs_address, IDX_CTRL))
      |=> !o_avs_readdata[TRIG_BIT])
      else $error("trigger read nonzero");

   // Sixth end nibble follows the write
   end_six_a: assert property (
      (wr_ok && hit(i_avs_address, IDX_END6)) |=> o_sixth_slot_end == $past(wd[3:0]))
      else $error("sixth end slot lost");

   // Frame pending flag follows the write
   pending_write_a: assert property (
      (wr_ok && hit(i_avs_address, IDX_IFS)) |=> o_ack_frame_pending == $past(wd[FP_BIT]))
      else $error("pending flag not stored");

   // Registers are eight bits wide; the upper lanes always read zero
   read_upper_zero_a: assert property (
      (i_avs_read && o_avs_waitrequest) |=> o_avs_readdata[31:8] == 24'h00_0000)
      else $error("upper read lanes nonzero");

   // Every access gets exactly one wait state
   bus_wait_a: assert property (
      ((i_avs_read || i_avs_write) && o_avs_waitrequest)
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("waitrequest timing wrong");
endmodule

/* File: core/gts_pkg.sv */
// Constants shared by the slot-transmit register bank and its sender
package gts_pkg;
   // ****************************************************************
   // Register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [5:0] IDX_CTRL  = 6'h1D;
   localparam logic [5:0] IDX_END23 = 6'h1E;
   localparam logic [5:0] IDX_END45 = 6'h1F;
   localparam logic [5:0] IDX_END6  = 6'h20;
   localparam logic [5:0] IDX_IFS   = 6'h21;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int RETRY_LSB = 6;
   localparam int SLOT_LSB  = 3;
   localparam int ACK_BIT   = 2;
   localparam int SEC_BIT   = 1;
   localparam int TRIG_BIT  = 0;
   localparam int HI_LSB    = 4;
   localparam int SPACE_LSB = 2;
   localparam int ALT_BIT   = 1;
   localparam int FP_BIT    = 0;

   // ****************************************************************
   // Reset values and symbol counts
   // ****************************************************************
   localparam logic [5:0] SPACE_RST      = 6'h21;
   localparam logic [3:0] END_RST        = 4'h0;
   localparam int         LIFS_SYMBOLS   = 40;
   localparam logic [3:0] LAST_SLOT_END  = 4'hF;
endpackage

/* File: core/gts_sender.sv */
// Attempt sequencer for the second slot FIFO: slot wait, retries, result
module gts_sender
   import gts_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset,
   input  wire logic       i_clk_en,
   input  wire logic       i_start,
   input  wire logic [1:0] i_retry_limit,
   input  wire logic       i_ack_request,
   input  wire logic [2:0] i_slot_number,
   input  wire logic [2:0] i_current_slot,
   input  wire logic       i_frame_done,
   input  wire logic       i_ack_seen,
   output logic            o_send,
   output logic            o_busy,
   output logic            o_done,
   output logic            o_success,
   output logic [1:0]      o_retries_used
);
   typedef enum logic [1:0] {S_IDLE, S_WAIT_SLOT, S_AIR} gts_state_t;

   gts_state_t  state_ff;
   logic [1:0]  count_ff;
   logic [1:0]  limit_ff;
   logic        more_ok;

   assign o_busy  = (state_ff != S_IDLE);
   assign more_ok = i_ack_request && !i_ack_seen && (count_ff < limit_ff);

   // ****************************************************************
   // Attempt state machine
   // ****************************************************************
   // Limit is caught at start so a rewrite mid-frame cannot shorten it
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_ff       <= S_IDLE;
         count_ff       <= 2'h0;
         limit_ff       <= 2'h0;
         o_send         <= 1'b0;
         o_done         <= 1'b0;
         o_success      <= 1'b0;
         o_retries_used <= 2'h0;
      end
      else if (i_clk_en)
      begin
         o_send <= 1'b0;
         o_done <= 1'b0;
         unique case (state_ff)
            S_IDLE:
            begin
               if (i_start)
               begin
                  count_ff <= 2'h0;
                  limit_ff <= i_retry_limit;
                  state_ff <= S_WAIT_SLOT;
               end
            end
            S_WAIT_SLOT:
            begin
               // Frame goes out only inside its own slot
               if (i_current_slot == i_slot_number)
               begin
                  o_send   <= 1'b1;
                  state_ff <= S_AIR;
               end
            end
            S_AIR:
            begin
               if (i_frame_done)
               begin
                  if (more_ok)
                  begin
                     count_ff <= count_ff + 2'h1;
                     state_ff <= S_WAIT_SLOT;
                  end
                  else
                  begin
                     o_done         <= 1'b1;
                     o_success      <= !i_ack_request || i_ack_seen;
                     o_retries_used <= count_ff;
                     state_ff       <= S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset || !i_clk_en);

   // Missing acknowledgement within budget brings a fresh attempt
   retry_again_a: assert property (
      (state_ff == S_AIR && i_frame_done && more_ok)
      |=> (state_ff == S_WAIT_SLOT && count_ff == $past(count_ff) + 2'h1))
      else $error("missed retransmit");

   // A send happens only in the programmed slot
   slot_match_a: assert property (
      $rose(o_send) |-> $past(i_current_slot == i_slot_number))
      else $error("send outside slot");
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the slot-transmit register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import gts_pkg::*;

   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic        clk_sys = 1'b0;
   logic        reset   = 1'b1;
   logic        clk_en  = 1'b1;
   logic [5:0]  address = 6'h00;
   logic        rd      = 1'b0;
   logic        wr      = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  ben     = 4'hF;
   logic [2:0]  cur_slot = 3'h0;
   logic        frame_done = 1'b0;
   logic        ack_seen   = 1'b0;
   logic [31:0] rdata, o_rd;
   logic        o_wait, o_send, o_busy, o_done, o_ok, o_ackreq, o_sec, o_alt, o_fp;
   logic [2:0]  o_slot;
   logic [3:0]  o_e2, o_e3, o_e4, o_e5, o_e6;
   logic [5:0]  o_lifs;
   int          err_total = 0;
   int          checked   = 0;

   // Free-running 50 MHz clock
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end

   gts_tx_slot_config_regs u_gts_tx_slot_config_regs (
      .i_clk_sys(clk_sys), .i_reset(reset), .i_clk_en(clk_en),
      .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(ben),
      .o_avs_readdata(o_rd), .o_avs_waitrequest(o_wait),
      .i_current_slot(cur_slot), .i_frame_done(frame_done), .i_ack_seen(ack_seen),
      .o_slot_fifo_b_send(o_send), .o_slot_fifo_b_busy(o_busy),
      .o_slot_fifo_b_done(o_done), .o_slot_fifo_b_success(o_ok),
      .o_slot_fifo_b_ack_request(o_ackreq), .o_slot_fifo_b_security_on(o_sec),
      .o_slot_fifo_b_slot_number(o_slot), .o_second_slot_end(o_e2),
      .o_third_slot_end(o_e3), .o_fourth_slot_end(o_e4), .o_fifth_slot_end(o_e5),
      .o_sixth_slot_end(o_e6), .o_long_spacing_symbols(o_lifs),
      .o_slot_fifo_alternate_on_fail(o_alt), .o_ack_frame_pending(o_fp)
   );

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds the request until waitrequest is seen low at a rising edge, then releases it
   task automatic bus_access(input logic is_wr, input logic [5:0] idx, input logic [7:0] d,
                             input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_sys);
      address <= idx;
      wdata   <= {24'h0, d};
      ben     <= be;
      wr      <= is_wr;
      rd      <= ~is_wr;
      do
      begin
         @(posedge clk_sys);
         n++;
      end while (o_wait !== 1'b0 && n < 50);
      rdata = o_rd;
      wr <= 1'b0;
      rd <= 1'b0;
      if (o_wait !== 1'b0)
      begin
         err_total++;
         report_and_stop();
      end
      // Callers look at outputs only once the landed write has settled
      @(negedge clk_sys);
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      bus_access(1'b0, idx, 8'h00, 4'hF);
      chk(rdata, {24'h0, exp});
   endtask

   // Waits a bounded time for a one-cycle pulse on the send or done output
   task automatic wait_pulse(input logic want_done);
      int n;
      n = 0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end while ((want_done ? o_done : o_send) !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         err_total++;
         report_and_stop();
      end
   endtask

   task automatic air_result(input logic acked);
      @(posedge clk_sys);
      frame_done <= 1'b1;
      ack_seen   <= acked;
      @(posedge clk_sys);
      frame_done <= 1'b0;
      ack_seen   <= 1'b0;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_reset();
      rd_chk(IDX_CTRL, 8'h00);
      rd_chk(IDX_END23, 8'h00);
      rd_chk(IDX_END45, 8'h00);
      rd_chk(IDX_END6, 8'h00);
      rd_chk(IDX_IFS, {SPACE_RST, 2'b00});
      chk({26'h0, o_lifs}, {26'h0, SPACE_RST});
      chk({30'h0, o_ackreq, o_sec}, 32'h0);
      $display("test_reset done");
   endtask

   task automatic test_slot_ends();
      bus_access(1'b1, IDX_END23, 8'hA5, 4'h1);
      bus_access(1'b1, IDX_END45, 8'h3C, 4'h1);
      bus_access(1'b1, IDX_END6, 8'h0F, 4'h1);
      rd_chk(IDX_END23, 8'hA5);
      rd_chk(IDX_END45, 8'h3C);
      rd_chk(IDX_END6, 8'h0F);
      chk({16'h0, o_e3, o_e2, o_e5, o_e4}, 32'hA53C);
      chk({28'h0, o_e6}, {28'h0, LAST_SLOT_END});
      bus_access(1'b1, IDX_END23, 8'h11, 4'h0);
      rd_chk(IDX_END23, 8'hA5);
      bus_access(1'b1, 6'h30, 8'h77, 4'h1);
      rd_chk(6'h30, 8'h00);
      $display("test_slot_ends done");
   endtask

   task automatic test_spacing();
      bus_access(1'b1, IDX_IFS, 8'h7B, 4'h1);
      rd_chk(IDX_IFS, 8'h7B);
      chk({24'h0, o_lifs, o_alt, o_fp}, 32'h7B);
      bus_access(1'b1, IDX_IFS, 8'h84, 4'h1);
      chk({24'h0, o_lifs, o_alt, o_fp}, 32'h84);
      $display("test_spacing done");
   endtask

   // Clock enable low: a held write must neither land nor be answered
   task automatic test_clock_hold();
      @(posedge clk_sys);
      clk_en  <= 1'b0;
      address <= IDX_IFS;
      wdata   <= 32'h0;
      wr      <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wr      <= 1'b0;
      clk_en  <= 1'b1;
      @(negedge clk_sys);
      chk({23'h0, o_wait, o_lifs, o_alt, o_fp}, 32'h184);
      $display("test_clock_hold done");
   endtask

   task automatic test_ctrl_fields();
      bus_access(1'b1, IDX_CTRL, 8'h6E, 4'h1);
      rd_chk(IDX_CTRL, 8'h2E);
      chk({27'h0, o_slot, o_ackreq, o_sec}, 32'h17);
      chk({31'h0, o_busy}, 32'h0);
      $display("test_ctrl_fields done");
   endtask

   // Limit two, slot three, ack wanted: one missed ack then success
   task automatic test_send_retry();
      int n;
      bus_access(1'b1, IDX_CTRL, 8'h9D, 4'h1);
      for (n = 0; n < 6; n++)
      begin
         @(negedge clk_sys);
         chk({30'h0, o_send, o_busy}, 32'h1);
      end
      @(posedge clk_sys);
      cur_slot <= 3'h3;
      wait_pulse(1'b0);
      air_result(1'b0);
      wait_pulse(1'b0);
      air_result(1'b1);
      wait_pulse(1'b1);
      chk({31'h0, o_ok}, 32'h1);
      repeat (3) @(negedge clk_sys);
      chk({31'h0, o_busy}, 32'h0);
      rd_chk(IDX_CTRL, 8'h5C);
      $display("test_send_retry done");
   endtask

   // Limit zero with no ack fails and keeps the old readback; no ack wanted succeeds
   task automatic test_send_outcomes();
      bus_access(1'b1, IDX_CTRL, 8'h1D, 4'h1);
      wait_pulse(1'b0);
      air_result(1'b0);
      wait_pulse(1'b1);
      chk({31'h0, o_ok}, 32'h0);
      rd_chk(IDX_CTRL, 8'h5C);
      bus_access(1'b1, IDX_CTRL, 8'hD9, 4'h1);
      wait_pulse(1'b0);
      air_result(1'b0);
      wait_pulse(1'b1);
      chk({31'h0, o_ok}, 32'h1);
      rd_chk(IDX_CTRL, 8'h18);
      $display("test_send_outcomes done");
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      test_reset();
      test_slot_ends();
      test_spacing();
      test_clock_hold();
      test_ctrl_fields();
      test_send_retry();
      test_send_outcomes();
      report_and_stop();
   end
endmodule
